// [shared/emi_pkg.sv]
// Shared constants and types of the external memory interface.
package emi_pkg;

  // ---------------------------------------------------------------
  // Memory mode codes
  // ---------------------------------------------------------------
  localparam logic [1:0] EMI_MODE_INT_ONLY = 2'h0;
  localparam logic [1:0] EMI_MODE_SPLIT_NB = 2'h1;
  localparam logic [1:0] EMI_MODE_SPLIT_BS = 2'h2;
  localparam logic [1:0] EMI_MODE_EXT_ONLY = 2'h3;

  // ---------------------------------------------------------------
  // Timing control register layout
  // ---------------------------------------------------------------
  localparam int         EMI_TC_AS_MSB = 7;
  localparam int         EMI_TC_AS_LSB = 6;
  localparam int         EMI_TC_WR_MSB = 5;
  localparam int         EMI_TC_WR_LSB = 2;
  localparam int         EMI_TC_AH_MSB = 1;
  localparam int         EMI_TC_AH_LSB = 0;
  localparam logic [7:0] EMI_TC_RESET  = 8'hff;

  // ---------------------------------------------------------------
  // Sequencing constants
  // ---------------------------------------------------------------
  localparam logic [3:0] EMI_CNT_ZERO   = 4'h0;
  localparam logic [3:0] EMI_END_LOAD   = 4'h2;
  localparam logic [3:0] EMI_ALE_ADD    = 4'h0;

  // ---------------------------------------------------------------
  // Sequencer states and module state
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    EMI_IDLE   = 3'b000,
    EMI_START  = 3'b001,
    EMI_ALE_HI = 3'b010,
    EMI_ALE_LO = 3'b011,
    EMI_SETUP  = 3'b100,
    EMI_STROBE = 3'b101,
    EMI_HOLD   = 3'b110,
    EMI_INT    = 3'b111
  } emi_state_e_t;

  typedef struct packed {
    emi_state_e_t st;
    logic         in_end;
    logic [3:0]   cnt;
    logic [15:0]  addr;
    logic [7:0]   wdata;
    logic         write;
    logic         hi_drive;
    logic [7:0]   rdata;
    logic         busy;
    logic         done;
    logic [7:0]   tc;
    logic [7:0]   addr_hi_o;
    logic         addr_hi_oe_n;
    logic [7:0]   addr_lo_o;
    logic         addr_lo_oe_n;
    logic [7:0]   data_o;
    logic         data_oe_n;
    logic         ale;
    logic         rd_n;
    logic         wr_n;
  } emi_reg_t;

endpackage

// [hdl/emi_top.sv]
// External data memory interface: on-chip RAM and off-chip parallel bus sequencer.
`timescale 1ns/10ps
module emi_top
  import emi_pkg::*;
#(
  parameter int RAM_AW     = 12,
  parameter int RAM_BOUND  = 4096
)
(
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        move_req,
  input  wire logic        move_write,
  input  wire logic        move_16bit,
  input  wire logic [15:0] data_pointer,
  input  wire logic [7:0]  index_register,
  input  wire logic [7:0]  page_high_byte_reg,
  input  wire logic [7:0]  move_wdata,
  input  wire logic        mux_select_bit,
  input  wire logic [1:0]  mem_mode,
  input  wire logic [1:0]  latch_pulse_width_field,
  input  wire logic        timing_wr,
  input  wire logic [7:0]  timing_wdata,
  input  wire logic [7:0]  data_i,
  output logic             move_busy,
  output logic             move_done,
  output logic [7:0]       move_rdata,
  output logic [7:0]       timing_control_reg,
  output logic [7:0]       addr_hi_o,
  output logic             addr_hi_oe_n,
  output logic [7:0]       addr_lo_o,
  output logic             addr_lo_oe_n,
  output logic [7:0]       data_o,
  output logic             data_oe_n,
  output logic             address_latch_strobe,
  output logic             rd_n,
  output logic             wr_n
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  emi_reg_t   r_q;
  emi_reg_t   r_d;
  logic [7:0] ram_q [0:(1<<RAM_AW)-1];

  logic [15:0]       eff_addr;
  logic              on_chip;
  logic              hi_drv;
  logic [1:0]        setup_c;
  logic [3:0]        strobe_c;
  logic [1:0]        hold_c;
  logic [3:0]        ale_load;
  logic [RAM_AW-1:0] ram_idx;
  logic              ram_we;
  logic              go_strobe;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  always_comb
  begin
    eff_addr = move_16bit ? data_pointer : {page_high_byte_reg, index_register};
    on_chip  = 1'b0;
    hi_drv   = 1'b0;
    case (mem_mode)
      EMI_MODE_INT_ONLY:
      begin
        on_chip = 1'b1;
      end
      EMI_MODE_SPLIT_NB:
      begin
        on_chip = ({16'h0000, eff_addr} < 32'(RAM_BOUND));
        hi_drv  = move_16bit;
      end
      EMI_MODE_SPLIT_BS:
      begin
        on_chip = ({16'h0000, eff_addr} < 32'(RAM_BOUND));
        hi_drv  = 1'b1;
      end
      EMI_MODE_EXT_ONLY:
      begin
        hi_drv  = move_16bit;
      end
      default:
      begin
        on_chip = 1'b1;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Timing fields
  // ---------------------------------------------------------------
  // programmable timing fields
  assign setup_c  = r_q.tc[EMI_TC_AS_MSB:EMI_TC_AS_LSB];
  assign strobe_c = r_q.tc[EMI_TC_WR_MSB:EMI_TC_WR_LSB];
  assign hold_c   = r_q.tc[EMI_TC_AH_MSB:EMI_TC_AH_LSB];
  assign go_strobe = (setup_c == 2'b00);
  assign ale_load = {2'b00, latch_pulse_width_field} + EMI_ALE_ADD;
  assign ram_idx  = r_q.addr[RAM_AW-1:0];
  assign ram_we   = (r_q.st == EMI_INT) && r_q.write;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb
  begin
    r_d      = r_q;
    r_d.done = 1'b0;
    if (timing_wr)
    begin
      r_d.tc = timing_wdata;
    end
    case (r_q.st)
      EMI_IDLE:
      begin
        if (move_req)
        begin
          r_d.busy     = 1'b1;
          r_d.addr     = eff_addr;
          r_d.wdata    = move_wdata;
          r_d.write    = move_write;
          r_d.hi_drive = hi_drv;
          r_d.st       = on_chip ? EMI_INT : EMI_START;
        end
      end
      EMI_INT:
      begin
        r_d.rdata = ram_q[ram_idx];
        r_d.busy  = 1'b0;
        r_d.done  = 1'b1;
        r_d.st    = EMI_IDLE;
      end
      EMI_START:
      begin
        if (r_q.in_end)
        begin
          if (r_q.cnt == EMI_CNT_ZERO)
          begin
            r_d.in_end       = 1'b0;
            r_d.busy         = 1'b0;
            r_d.done         = 1'b1;
            r_d.addr_hi_oe_n = 1'b1;
            r_d.addr_lo_oe_n = 1'b1;
            r_d.data_oe_n    = 1'b1;
            r_d.st           = EMI_IDLE;
          end
          else
          begin
            r_d.cnt = r_q.cnt - 4'h1;
          end
        end
        else
        begin
          r_d.addr_hi_o    = r_q.addr[15:8];
          r_d.addr_hi_oe_n = !r_q.hi_drive;
          r_d.addr_lo_o    = r_q.addr[7:0];
          if (!mux_select_bit)
          begin
            r_d.addr_lo_oe_n = 1'b1;
            r_d.data_o       = r_q.addr[7:0];
            r_d.data_oe_n    = 1'b0;
            r_d.ale          = 1'b1;
            r_d.cnt          = ale_load;
            r_d.st           = EMI_ALE_HI;
          end
          else
          begin
            r_d.addr_lo_oe_n = 1'b0;
            r_d.data_o       = r_q.wdata;
            r_d.data_oe_n    = !r_q.write;
            r_d.cnt          = go_strobe ? strobe_c : {2'b00, setup_c} - 4'h1;
            r_d.rd_n         = r_q.write || !go_strobe;
            r_d.wr_n         = !r_q.write || !go_strobe;
            r_d.st           = go_strobe ? EMI_STROBE : EMI_SETUP;
          end
        end
      end
      EMI_ALE_HI:
      begin
        if (r_q.cnt == EMI_CNT_ZERO)
        begin
          r_d.ale = 1'b0;
          r_d.cnt = ale_load;
          r_d.st  = EMI_ALE_LO;
        end
        else
        begin
          r_d.cnt = r_q.cnt - 4'h1;
        end
      end
      EMI_ALE_LO:
      begin
        if (r_q.cnt == EMI_CNT_ZERO)
        begin
          r_d.data_o    = r_q.wdata;
          r_d.data_oe_n = !r_q.write;
          r_d.cnt       = go_strobe ? strobe_c : {2'b00, setup_c} - 4'h1;
          r_d.rd_n      = r_q.write || !go_strobe;
          r_d.wr_n      = !r_q.write || !go_strobe;
          r_d.st        = go_strobe ? EMI_STROBE : EMI_SETUP;
        end
        else
        begin
          r_d.cnt = r_q.cnt - 4'h1;
        end
      end
      EMI_SETUP:
      begin
        if (r_q.cnt == EMI_CNT_ZERO)
        begin
          r_d.cnt  = strobe_c;
          r_d.rd_n = r_q.write;
          r_d.wr_n = !r_q.write;
          r_d.st   = EMI_STROBE;
        end
        else
        begin
          r_d.cnt = r_q.cnt - 4'h1;
        end
      end
      EMI_STROBE:
      begin
        if (r_q.cnt == EMI_CNT_ZERO)
        begin
          r_d.rdata = data_i;
          r_d.rd_n  = 1'b1;
          r_d.wr_n  = 1'b1;
          if (hold_c != 2'b00)
          begin
            r_d.cnt = {2'b00, hold_c} - 4'h1;
            r_d.st  = EMI_HOLD;
          end
          else
          begin
            r_d.cnt    = EMI_END_LOAD;
            r_d.in_end = 1'b1;
            r_d.st     = EMI_START;
          end
        end
        else
        begin
          r_d.cnt = r_q.cnt - 4'h1;
        end
      end
      EMI_HOLD:
      begin
        if (r_q.cnt == EMI_CNT_ZERO)
        begin
          r_d.cnt    = EMI_END_LOAD;
          r_d.in_end = 1'b1;
          r_d.st     = EMI_START;
        end
        else
        begin
          r_d.cnt = r_q.cnt - 4'h1;
        end
      end
      default:
      begin
        r_d.st = EMI_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      r_q              <= '0;
      r_q.tc           <= EMI_TC_RESET;
      r_q.addr_hi_oe_n <= 1'b1;
      r_q.addr_lo_oe_n <= 1'b1;
      r_q.data_oe_n    <= 1'b1;
      r_q.rd_n         <= 1'b1;
      r_q.wr_n         <= 1'b1;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (ram_we)
    begin
      ram_q[ram_idx] <= r_q.wdata;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign move_busy            = r_q.busy;
  assign move_done            = r_q.done;
  assign move_rdata           = r_q.rdata;
  assign timing_control_reg   = r_q.tc;
  assign addr_hi_o            = r_q.addr_hi_o;
  assign addr_hi_oe_n         = r_q.addr_hi_oe_n;
  assign addr_lo_o            = r_q.addr_lo_o;
  assign addr_lo_oe_n         = r_q.addr_lo_oe_n;
  assign data_o               = r_q.data_o;
  assign data_oe_n            = r_q.data_oe_n;
  assign address_latch_strobe = r_q.ale;
  assign rd_n                 = r_q.rd_n;
  assign wr_n                 = r_q.wr_n;

endmodule

// [bench/emi_properties.sv]
// Port timing checker of the external memory interface.
`timescale 1ns/10ps
module emi_properties
  import emi_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       srst,
  input wire logic       mux_select_bit,
  input wire logic [1:0] latch_pulse_width_field,
  input wire logic       move_busy,
  input wire logic       move_done,
  input wire logic [7:0] timing_control_reg,
  input wire logic       addr_lo_oe_n,
  input wire logic       data_oe_n,
  input wire logic       address_latch_strobe,
  input wire logic       rd_n,
  input wire logic       wr_n
);
  logic [2:0] ale_hi_q;
  logic [2:0] ale_len;

  // Counts the cycles for which the latch strobe has stood high.
  always_ff @(posedge ref_clk)
  begin
    ale_hi_q <= address_latch_strobe ? ale_hi_q + 3'h1 : 3'h0;
  end
  assign ale_len = {1'b0, latch_pulse_width_field} + 3'h1;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  a_done_pulse: assert property (move_done |=> !move_done)
    else $error("done longer than one cycle");
  a_busy_to_done: assert property ($fell(move_busy) |-> move_done)
    else $error("busy ended without done");
  a_strobe_in_busy: assert property ((!rd_n || !wr_n) |-> move_busy && !address_latch_strobe)
    else $error("strobe outside access or with latch strobe");
  a_no_ale_nonmux: assert property (mux_select_bit |-> !address_latch_strobe)
    else $error("latch strobe in non-multiplexed form");
  a_lo_nonmux: assert property (mux_select_bit && !rd_n |-> !addr_lo_oe_n)
    else $error("low address not driven");
  a_lo_mux_off: assert property (!mux_select_bit |-> addr_lo_oe_n)
    else $error("low address pins driven in multiplexed form");
  a_ale_drives: assert property (address_latch_strobe |-> !data_oe_n)
    else $error("low address byte not driven under latch strobe");
  a_ale_low_gap: assert property ($fell(address_latch_strobe) |-> rd_n && wr_n)
    else $error("strobe without latch low time");
  a_ale_high_len: assert property ($fell(address_latch_strobe) |-> ale_hi_q == ale_len)
    else $error("latch strobe high time wrong");
  a_reset_timing: assert property ($fell(srst) |-> timing_control_reg == 8'hff)
    else $error("timing register not at maximum after reset");
  a_wr_data: assert property (!wr_n |-> !data_oe_n)
    else $error("write data not driven");

  c_mux: cover property ($fell(address_latch_strobe));
  c_read: cover property (!rd_n && mux_select_bit);
  c_onchip: cover property ($rose(move_busy) ##1 move_done);
endmodule

bind emi_top emi_properties u_chk (.*);

// [bench/emi_sram_model.sv]
// Behavioural parallel memory with address latch beyond the bus.
`timescale 1ns/10ps
module emi_sram_model
  import emi_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic [7:0] addr_hi_o,
  input  wire logic       addr_hi_oe_n,
  input  wire logic [7:0] addr_lo_o,
  input  wire logic       addr_lo_oe_n,
  input  wire logic [7:0] data_o,
  input  wire logic       address_latch_strobe,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic [7:0] port_hi,
  input  wire logic [1:0] rd_lat,
  output logic      [7:0] data_i
);
  logic [7:0]  mem [0:65535];
  logic [7:0]  lat_q;
  logic [7:0]  last_q;
  logic [3:0]  rc_q;
  logic [15:0] a;

  // ---------------------------------------------------------------
  // Latch and memory
  // ---------------------------------------------------------------
  // transparent then holding
  always @* if (address_latch_strobe) lat_q = data_o;
  // Undriven upper pins keep the port latch value.
  assign a = {addr_hi_oe_n ? port_hi : addr_hi_o, addr_lo_oe_n ? lat_q : addr_lo_o};
  // Data is valid only after rd_lat strobe cycles; otherwise it toggles.
  assign data_i = (!rd_n && rc_q >= {2'h0, rd_lat}) ? mem[a] : ~last_q;
  always @(posedge ref_clk)
  begin
    rc_q <= rd_n ? 4'h0 : rc_q + 4'h1;
    if (!wr_n) mem[a] <= data_o;
    last_q <= data_i;
  end
endmodule

// [bench/tb_top.sv]
// Self-checking bench of the external memory interface.
`timescale 1ns/10ps
module tb_top
  import emi_pkg::*;
  ;
  logic        ref_clk = 1'b0;
  logic        srst, move_req, move_write, move_16bit, mux_select_bit, timing_wr;
  logic        move_busy, move_done, addr_hi_oe_n, addr_lo_oe_n, data_oe_n;
  logic        address_latch_strobe, rd_n, wr_n;
  logic [15:0] data_pointer;
  logic [7:0]  index_register, page_high_byte_reg, move_wdata, timing_wdata, data_i;
  logic [7:0]  move_rdata, timing_control_reg, addr_hi_o, addr_lo_o, data_o, port_hi;
  logic [1:0]  mem_mode, latch_pulse_width_field, rd_lat;
  int          miscompares, checks_done, cyc, ts, tw, th;

  always #12.5 ref_clk = ~ref_clk;
  emi_top #(.RAM_AW(12), .RAM_BOUND(4096)) dut (.*);
  emi_sram_model mdl (.*);

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: byte %h not %h", $time, got, exp);
    end
  endtask
  task automatic chk_cyc(input int got, input int exp);
    checks_done++;
    if (got != exp)
    begin
      miscompares++;
      $display("wrong value at %0t: %0d cycles not %0d", $time, got, exp);
    end
  endtask
  task automatic set_tc(input int s, input int w, input int h);
    @(negedge ref_clk);
    timing_wr = 1'b1;
    timing_wdata = {s[1:0], w[3:0], h[1:0]};
    ts = s;
    tw = w;
    th = h;
    @(negedge ref_clk);
    timing_wr = 1'b0;
    chk_val(timing_control_reg, timing_wdata);
  endtask
  function automatic int offn();
    return 5 + ts + tw + th + (mux_select_bit ? 0 : 2 * (latch_pulse_width_field + 1));
  endfunction
  task automatic mv(input logic wr, input logic w16, input logic [15:0] a,
                    input logic [7:0] d, input int n);
    int k;
    @(negedge ref_clk);
    move_req = 1'b1;
    move_write = wr;
    move_16bit = w16;
    move_wdata = d;
    data_pointer = w16 ? a : ~a;
    {page_high_byte_reg, index_register} = w16 ? ~a : a;
    @(negedge ref_clk);
    move_req = 1'b0;
    for (k = 0; move_done !== 1'b1 && k < 64; k++) @(negedge ref_clk);
    chk_cyc(k, n);
    if (!wr) chk_val(move_rdata, d);
  endtask
  task automatic tdone(input int t);
    $display("test %0d finished", t);
  endtask

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      miscompares++;
      end_of_test();
    end
  end
  initial
  begin
    {move_req, move_write, move_16bit, timing_wr, data_pointer, index_register} = '0;
    {page_high_byte_reg, move_wdata, timing_wdata, latch_pulse_width_field} = '0;
    srst = 1'b1;
    mux_select_bit = 1'b1;
    mem_mode = 2'h3;
    port_hi = 8'h90;
    rd_lat = 2'h0;
    ts = 3;
    tw = 15;
    th = 3;
    repeat (21) @(negedge ref_clk);
    srst = 1'b0;
    chk_val(timing_control_reg, 8'hff);
    mv(1'b1, 1'b1, 16'h4321, 8'ha5, offn());
    mv(1'b0, 1'b1, 16'h4321, 8'ha5, offn());
    tdone(1);
    set_tc(0, 0, 0);
    mv(1'b1, 1'b1, 16'h0123, 8'h3c, 5);
    mv(1'b0, 1'b1, 16'h0123, 8'h3c, 5);
    mux_select_bit = 1'b0;
    mv(1'b0, 1'b1, 16'h0123, 8'h3c, 7);
    tdone(2);
    rd_lat = 2'h2;
    set_tc(1, 2, 1);
    for (int l = 0; l < 4; l++)
    begin
      latch_pulse_width_field = l[1:0];
      mv(1'b1, 1'b1, 16'h8000 + l[15:0], 8'h50 + l[7:0], offn());
      mv(1'b0, 1'b1, 16'h8000 + l[15:0], 8'h50 + l[7:0], offn());
    end
    tdone(3);
    mem_mode = 2'h2;
    mv(1'b1, 1'b0, 16'h1234, 8'h77, offn());
    mv(1'b0, 1'b1, 16'h1234, 8'h77, offn());
    mem_mode = 2'h1;
    mv(1'b1, 1'b0, 16'h5566, 8'h88, offn());
    mv(1'b0, 1'b1, 16'h9066, 8'h88, offn());
    mem_mode = 2'h3;
    mv(1'b1, 1'b0, 16'h0077, 8'h99, offn());
    mv(1'b0, 1'b1, 16'h9077, 8'h99, offn());
    tdone(4);
    mux_select_bit = 1'b1;
    mem_mode = 2'h1;
    mv(1'b1, 1'b1, 16'h0fff, 8'he1, 1);
    mv(1'b0, 1'b1, 16'h0fff, 8'he1, 1);
    mv(1'b1, 1'b1, 16'h1000, 8'he2, offn());
    mem_mode = 2'h0;
    mv(1'b1, 1'b1, 16'h0123, 8'hc4, 1);
    mv(1'b0, 1'b1, 16'h2123, 8'hc4, 1);
    mv(1'b0, 1'b0, 16'h3123, 8'hc4, 1);
    mem_mode = 2'h3;
    mv(1'b0, 1'b1, 16'h0123, 8'h3c, offn());
    tdone(5);
    end_of_test();
  end
endmodule
